// ---- bench/del_event_latch_assertions.sv ----
// Port-level assertion checker for the event latch
`timescale 1ns/1ps
module del_chk (
   input wire clock, // Clock
   input wire rst_n, // Reset, low
   input wire psel, // Select
   input wire penable, // Enable
   input wire pwrite, // Direction
   input wire [11:0] paddr, // Address
   input wire [31:0] prdata, // Read data
   input wire pready, // Ready
   input wire pslverr, // Error
   input wire [1:0] xtal_valid, // Crystal valid
   input wire xtal_sel_r, // Selected crystal
   input wire irq_r, // Interrupt
   input wire fault_r // Fault
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   wire acc = psel && penable && pready; // Completed access
   a_ready_setup: assert property (psel && !penable |=> pready) else $error("ready late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   a_unmapped_err: assert property (acc && paddr > 12'h018 |-> pslverr) else $error("no error");
   a_mapped_ok: assert property (acc && paddr <= 12'h018 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("false error");
   a_resv_zero: assert property (acc && !pwrite && paddr == 12'h000 |->
      prdata[31:29] == 3'h0 && prdata[13:0] == 14'h0) else $error("reserved set");
   // Sticky flags: only a register write may drop the outputs
   a_irq_sticky: assert property ($fell(irq_r) |->
      $past(psel && pwrite) || $past(psel && pwrite, 2)) else $error("irq dropped");
   a_fault_sticky: assert property ($fell(fault_r) |->
      $past(psel && pwrite) || $past(psel && pwrite, 2)) else $error("fault dropped");
   a_dual_hold: assert property ((xtal_valid == 2'h0 && !psel)[*8] |=>
      $stable(xtal_sel_r)) else $error("switched to dead crystal");
endmodule // del_chk
bind del_event_latch del_chk i_chk (.clock(clock), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .xtal_valid(xtal_valid), .xtal_sel_r(xtal_sel_r), .irq_r(irq_r),
   .fault_r(fault_r));

// ---- bench/tb_top.sv ----
// Self-checking testbench for the event latch
`timescale 1ns/1ps
`include "del_map.vh"
module tb_top;
   logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0; // Clock, reset, bus
   logic [11:0] paddr = 0; // Address
   logic [31:0] pwdata = 0, prdata, r, sig = 0; // Bus data, signature
   logic pready, pslverr, perr, xsel, irq, fault, rl = 0; // Outputs, reload fail
   logic [28:14] ev = 0; // Level events by flag position
   logic [6:0] mc = 0; // Complement monitors
   logic [1:0] pl = 0, xen = 2'h3, xv = 2'h3; // Pulses, crystals
   int errors = 0, cmp_count = 0; // Counters
   del_event_latch i_del_event_latch (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cal_timeout(ev[28]), .cal_done(pl[0]),
      .xtal_enabled(xen), .otp_load_fail_in(ev[27]), .otp_crc_err_in(ev[26]),
      .bus_crc_err(ev[25]), .sig_check_done(pl[1]), .sig_calc_in(sig), .reload_fail(rl),
      .xtal_valid(xv), .output_clock_monitor_fail_t(ev[20:14]),
      .output_clock_monitor_fail_c(mc), .xtal_sel_r(xsel), .irq_r(irq), .fault_r(fault));
   initial forever #4 clock = ~clock; // 125 MHz
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // One bus transfer, held until ready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) errors++;
      r = prdata;
      perr = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk(r, e);
   endtask
   // Pulse the edge-checked inputs, then let the sync settle
   task automatic pz(input logic [1:0] v);
      pl <= v;
      cyc(3);
      pl <= 0;
      cyc(6);
   endtask
   task automatic t_regs;
      rdc(`DEL_OFF_EVENT, 0);
      apb(1, `DEL_OFF_IRQ_EN, 32'hFFFFFFFF);
      rdc(`DEL_OFF_IRQ_EN, `DEL_IRQEN_MASK);
      apb(1, `DEL_OFF_FAULT_EN, 32'hFFFFFFFF);
      rdc(`DEL_OFF_FAULT_EN, `DEL_FLTEN_MASK);
      apb(1, `DEL_OFF_IRQ_EN, 0);
      apb(1, `DEL_OFF_FAULT_EN, 0);
      rdc(12'h100, 0);
      chk(perr, 1);
   endtask
   // Each level source, both monitor legs; partial and full clears
   task automatic t_events;
      for (int b = 14; b <= 28; b++) begin
         for (int c = 0; c < 2; c++) begin
            if ((b > 20 && b < 25) || (c == 1 && b > 20)) continue;
            if (c == 1) mc <= 7'h01 << (b - 14);
            else ev <= 15'h0001 << (b - 14);
            cyc(2);
            ev <= 0; mc <= 0;
            cyc(6);
            rdc(`DEL_OFF_EVENT, 32'h1 << b);
            apb(1, `DEL_OFF_EVENT, `DEL_EVT_MASK & ~(32'h1 << b));
            rdc(`DEL_OFF_EVENT, 32'h1 << b);
            apb(1, `DEL_OFF_EVENT, 32'hFFFFFFFF);
            rdc(`DEL_OFF_EVENT, 0);
         end
      end
   endtask
   // Signature check in both modes, then calibration with no crystal
   task automatic t_sig_cal;
      apb(1, `DEL_OFF_SIG_EXP, 32'h5A5A0001);
      sig <= 32'h5A5A0002;
      pz(2'h2);
      rdc(`DEL_OFF_EVENT, 32'h1 << 23);
      rdc(`DEL_OFF_SIG_CALC, 32'h5A5A0002);
      apb(1, `DEL_OFF_EVENT, 32'hFFFFFFFF);
      apb(1, `DEL_OFF_CTRL, 32'h1);
      rl <= 1;
      pz(2'h2);
      rdc(`DEL_OFF_EVENT, 32'h1 << 24);
      xen <= 0;
      rl <= 0;
      apb(1, `DEL_OFF_EVENT, 32'hFFFFFFFF);
      pz(2'h1);
      rdc(`DEL_OFF_EVENT, 32'h1 << 28);
      xen <= 2'h3;
      apb(1, `DEL_OFF_EVENT, 32'hFFFFFFFF);
   endtask
   // Automatic switchover, then both crystals lost
   task automatic t_xtal;
      apb(1, `DEL_OFF_CTRL, 32'h2);
      xv <= 2'h2;
      cyc(10);
      chk(xsel, 1);
      rdc(`DEL_OFF_EVENT, 32'h1 << 21);
      xv <= 2'h0;
      cyc(12);
      chk(xsel, 1);
      rdc(`DEL_OFF_EVENT, 32'h3 << 21);
      xv <= 2'h3;
      apb(1, `DEL_OFF_EVENT, 32'hFFFFFFFF);
   endtask
   // Interrupt and fault gating, mask and clear
   task automatic t_irq;
      apb(1, `DEL_OFF_IRQ_EN, 32'h1 << 25);
      apb(1, `DEL_OFF_FAULT_EN, 32'h1 << 25);
      ev <= 15'h0800;
      cyc(2);
      ev <= 0;
      cyc(6);
      chk({irq, fault}, 2'h2);
      apb(1, `DEL_OFF_IRQ_EN, 0);
      apb(1, `DEL_OFF_FAULT_EN, 32'h82000000);
      cyc(2);
      chk({irq, fault}, 2'h1);
      apb(1, `DEL_OFF_EVENT, 32'h1 << 25);
      cyc(2);
      chk(fault, 0);
   endtask
   initial begin
      cyc(12);
      rst_n <= 1;
      t_regs;
      t_events;
      t_sig_cal;
      t_xtal;
      t_irq;
      results;
   end
   // Watchdog well beyond the expected run
   initial begin
      #400000;
      errors++;
      results;
   end
   task results;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
endmodule // tb_top

// ---- hdl/del_event_latch.v ----
// Upper device event latch with APB registers, interrupt and fault outputs
`timescale 1ns/1ps
`include "del_map.vh"
module del_event_latch (
   input wire clock, // 125 MHz system clock
   input wire rst_n, // Async reset, low
   input wire psel, // APB select
   input wire penable, // APB enable
   input wire pwrite, // APB direction
   input wire [11:0] paddr, // APB byte address
   input wire [31:0] pwdata, // APB write data
   output reg [31:0] prdata, // APB read data
   output reg pready, // APB ready
   output reg pslverr, // APB error
   input wire cal_timeout, // Calibration timed out
   input wire cal_done, // Calibration ended (pulse level)
   input wire [1:0] xtal_enabled, // Crystal enables
   input wire otp_load_fail_in, // Startup load failed
   input wire otp_crc_err_in, // Startup load CRC error
   input wire bus_crc_err, // Serial bus CRC error
   input wire sig_check_done, // Signature check finished
   input wire [31:0] sig_calc_in, // Computed CRC-32 signature
   input wire reload_fail, // Register reload failed
   input wire [1:0] xtal_valid, // Crystal valid levels
   input wire [6:0] output_clock_monitor_fail_t, // True-leg monitor fails 11..5
   input wire [6:0] output_clock_monitor_fail_c, // Complement-leg monitor fails
   output reg xtal_sel_r, // Selected crystal for loop
   output reg irq_r, // Interrupt, high level
   output reg fault_r // Device fault to GPIO, high
);
   // Synchronised inputs
   wire [42:0] raw_in; // Bundle of asynchronous levels
   wire [42:0] syn; // Synchronised bundle
   // Signature word is only used on a done edge, two cycles after it settles
   assign raw_in = {sig_calc_in, output_clock_monitor_fail_t,
                    xtal_valid, cal_timeout, bus_crc_err};
   wire [13:0] ev_raw; // Remaining levels
   wire [13:0] ev_syn; // Synchronised remaining levels
   assign ev_raw = {output_clock_monitor_fail_c, cal_done, xtal_enabled,
                    otp_load_fail_in, otp_crc_err_in, sig_check_done, reload_fail};

   del_sync #(.W(43)) u_sync_a (
      .clock(clock),
      .rst_n(rst_n),
      .async_in(raw_in),
      .sync_out(syn)
   );
   del_sync #(.W(14)) u_sync_b (
      .clock(clock),
      .rst_n(rst_n),
      .async_in(ev_raw),
      .sync_out(ev_syn)
   );

   wire [31:0] s_sig = syn[42:11]; // Computed signature
   wire [6:0] s_mon_t = syn[10:4]; // True-leg fails
   wire [1:0] s_valid = syn[3:2]; // Crystal valid
   wire cal_to_w = syn[1]; // Calibration timeout level
   wire s_bus_crc = syn[0]; // Bus CRC error
   wire [6:0] s_mon_c = ev_syn[13:7]; // Complement-leg fails
   wire s_cal_done = ev_syn[6]; // Calibration done
   wire [1:0] s_xen = ev_syn[5:4]; // Crystal enables
   wire s_otp_fail = ev_syn[3]; // Load fail
   wire s_otp_crc = ev_syn[2]; // Load CRC
   wire s_sig_done = ev_syn[1]; // Signature check done
   wire s_reload_fail = ev_syn[0]; // Reload fail

   // Registers
   reg [31:0] event_r; // Sticky event flags
   reg [31:0] irq_en_r; // Interrupt enables
   reg [31:0] fault_en_r; // Fault enables
   reg [31:0] sig_exp_r; // Expected signature
   reg [31:0] sig_calc_r; // Captured computed signature
   reg [3:0] ctrl_r; // Mode and selection control
   reg [2:0] edge_r; // Previous levels for edge detect
   reg [31:0] evt_set_nxt; // Set requests this cycle
   reg xtal_sel_nxt; // Next crystal selection
   reg [31:0] event_nxt; // Next flag value

   // APB strobes
   wire acc = psel & penable; // Access phase
   wire wr = acc & pwrite; // Write at access
   function sel; // Address match
      input [11:0] a;
      input [11:0] off;
      begin
         sel = (a == off);
      end
   endfunction
   wire mapped = sel(paddr, `DEL_OFF_EVENT) | sel(paddr, `DEL_OFF_IRQ_EN)
               | sel(paddr, `DEL_OFF_FAULT_EN) | sel(paddr, `DEL_OFF_SIG_CALC)
               | sel(paddr, `DEL_OFF_SIG_EXP) | sel(paddr, `DEL_OFF_CTRL)
               | sel(paddr, `DEL_OFF_STATUS);

   // Event detection and crystal selection
   always @* begin
      evt_set_nxt = `DEL_RST_32;
      xtal_sel_nxt = xtal_sel_r;
      // Timeout, or calibration run with no crystal and no bypass
      evt_set_nxt[`DEL_B_CAL] = cal_to_w
         | (s_cal_done & ~edge_r[0] & ~ctrl_r[`DEL_C_CAL_BYP] & (s_xen == 2'h0));
      evt_set_nxt[`DEL_B_OTP_FAIL] = s_otp_fail;
      evt_set_nxt[`DEL_B_OTP_CRC] = s_otp_crc;
      evt_set_nxt[`DEL_B_BUS_CRC] = s_bus_crc;
      // Signature compare at end of check
      if (s_sig_done & ~edge_r[1] & (s_sig != sig_exp_r)) begin
         evt_set_nxt[`DEL_B_SIG_FAIL] = ~ctrl_r[`DEL_C_SIG_MODE];
      end
      // Reload fail only counts after a mismatch in reload mode
      evt_set_nxt[`DEL_B_SIG_RELOAD] = s_reload_fail & ctrl_r[`DEL_C_SIG_MODE]
         & (sig_calc_r != sig_exp_r);
      evt_set_nxt[`DEL_B_FREQ_HI:`DEL_B_FREQ_LO] = s_mon_t | s_mon_c;
      if (ctrl_r[`DEL_C_AUTO_SEL]) begin
         if (!s_valid[xtal_sel_r]) begin
            if (s_valid[~xtal_sel_r]) begin
               xtal_sel_nxt = ~xtal_sel_r; // Automatic switchover
               evt_set_nxt[`DEL_B_SWITCH] = 1'b1;
            end else if (edge_r[2]) begin
               // Stay put when both are bad
               evt_set_nxt[`DEL_B_DUAL] = 1'b1;
            end
         end
      end else begin
         xtal_sel_nxt = ctrl_r[`DEL_C_MAN_SEL]; // Manual selection
      end
      // Set wins over a clear in the same cycle
      event_nxt = event_r;
      if (wr & sel(paddr, `DEL_OFF_EVENT)) begin
         event_nxt = event_r & ~pwdata;
      end
      event_nxt = (event_nxt | evt_set_nxt) & `DEL_EVT_MASK;
   end

   // Register file and flags
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         event_r <= `DEL_RST_32;
         irq_en_r <= `DEL_RST_32;
         fault_en_r <= `DEL_RST_32;
         sig_exp_r <= `DEL_RST_32;
         sig_calc_r <= `DEL_RST_32;
         ctrl_r <= 4'h0;
         edge_r <= 3'h0;
         xtal_sel_r <= 1'b0;
      end else begin
         event_r <= event_nxt;
         edge_r <= {s_valid[xtal_sel_r], s_sig_done, s_cal_done};
         xtal_sel_r <= xtal_sel_nxt;
         if (s_sig_done & ~edge_r[1]) begin
            sig_calc_r <= s_sig; // Readable computed signature
         end
         if (wr) begin
            if (sel(paddr, `DEL_OFF_IRQ_EN)) irq_en_r <= pwdata & `DEL_IRQEN_MASK;
            if (sel(paddr, `DEL_OFF_FAULT_EN)) fault_en_r <= pwdata & `DEL_FLTEN_MASK;
            if (sel(paddr, `DEL_OFF_SIG_EXP)) sig_exp_r <= pwdata;
            if (sel(paddr, `DEL_OFF_CTRL)) ctrl_r <= pwdata[3:0];
         end
      end
   end

   // APB answer: one wait-free access, unmapped reports error
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= `DEL_RST_32;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable; // Ready in access phase
         pslverr <= psel & ~penable & ~mapped;
         prdata <= `DEL_RST_32;
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               `DEL_OFF_EVENT: prdata <= event_r;
               `DEL_OFF_IRQ_EN: prdata <= irq_en_r;
               `DEL_OFF_FAULT_EN: prdata <= fault_en_r;
               `DEL_OFF_SIG_CALC: prdata <= sig_calc_r;
               `DEL_OFF_SIG_EXP: prdata <= sig_exp_r;
               `DEL_OFF_CTRL: prdata <= {28'h0000000, ctrl_r};
               `DEL_OFF_STATUS: prdata <= {31'h00000000, xtal_sel_r};
               default: prdata <= `DEL_RST_32;
            endcase
         end
      end
   end

   // Interrupt and fault aggregation
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
         fault_r <= 1'b0;
      end else begin
         irq_r <= |(event_r & irq_en_r);
         fault_r <= fault_en_r[`DEL_FLTEN_ALL] & |(event_r & fault_en_r & `DEL_EVT_MASK);
      end
   end
endmodule // del_event_latch

// ---- hdl/del_map.vh ----
// Register map, field positions and reset values for the event latch block
`ifndef DEL_MAP_VH
`define DEL_MAP_VH
`define DEL_OFF_EVENT 12'h000
`define DEL_OFF_IRQ_EN 12'h004
`define DEL_OFF_FAULT_EN 12'h008
`define DEL_OFF_SIG_CALC 12'h00C
`define DEL_OFF_SIG_EXP 12'h010
`define DEL_OFF_CTRL 12'h014
`define DEL_OFF_STATUS 12'h018
`define DEL_EVT_MASK 32'h1FFFC000
`define DEL_IRQEN_MASK 32'h1FFFC000
`define DEL_FLTEN_MASK 32'h9FFFC000
`define DEL_FLTEN_ALL 31
`define DEL_B_CAL 28
`define DEL_B_OTP_FAIL 27
`define DEL_B_OTP_CRC 26
`define DEL_B_BUS_CRC 25
`define DEL_B_SIG_RELOAD 24
`define DEL_B_SIG_FAIL 23
`define DEL_B_DUAL 22
`define DEL_B_SWITCH 21
`define DEL_B_FREQ_HI 20
`define DEL_B_FREQ_LO 14
`define DEL_C_SIG_MODE 0
`define DEL_C_AUTO_SEL 1
`define DEL_C_CAL_BYP 2
`define DEL_C_MAN_SEL 3
`define DEL_RST_32 32'h00000000
`endif

// ---- hdl/del_sync.v ----
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module del_sync #(
   parameter W = 1 // Bundle width
) (
   input wire clock, // System clock
   input wire rst_n, // Async reset, low
   input wire [W-1:0] async_in, // Levels from outside
   output reg [W-1:0] sync_out // Synchronised levels
);
   reg [W-1:0] meta_r; // First stage, read only by second

   // Plain double flop; nothing else taps the first stage
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule // del_sync
